// file: radio_seq_pkg.sv
// Purpose: constants and types for the radio transmit/receive sequencer
// Assumes: 40 MHz mclk_i
// Notes:   times held in their own units, cycle counts derived here
package radio_seq_pkg;
    localparam int          CLK_HZ           = 40_000_000;
    localparam int          TALK_HOLD_US     = 1000;
    localparam int          TALK_HOLD_CYC    = (CLK_HZ / 1_000_000) * TALK_HOLD_US + 1;
    localparam int          WARN_SECONDS     = 5;
    localparam int          TONE_SQUELCH_HZ  = 150;
    localparam int          TONE_SQ_HALF     = CLK_HZ / (2 * TONE_SQUELCH_HZ);
    localparam int          SYNC_PRE_MS      = 100;
    localparam int          SYNC_PRE_CYC     = (CLK_HZ / 1000) * SYNC_PRE_MS;
    localparam int          INIT_COPY_WORDS  = 20;
    localparam logic [3:0]  VOL_SQ_OPEN      = 4'h0007;
    localparam logic [3:0]  VOL_MAX_NORMAL   = 4'h0006;
    localparam logic [7:0]  LIMIT_30         = 8'h001E;
    localparam logic [7:0]  LIMIT_60         = 8'h003C;
    localparam logic [7:0]  LIMIT_90         = 8'h005A;
    localparam logic [7:0]  LIMIT_120        = 8'h0078;
    localparam logic [1:0]  MODE_CLEAR       = 2'h0;
    localparam logic [1:0]  MODE_KEY_A       = 2'h1;
    localparam logic [1:0]  MODE_KEY_B       = 2'h2;
    localparam logic [1:0]  MODE_ZERO        = 2'h3;
    localparam logic [1:0]  ROUTE_MUTE       = 2'h0;
    localparam logic [1:0]  ROUTE_CLEAR      = 2'h1;
    localparam logic [1:0]  ROUTE_RAW        = 2'h2;
    localparam logic [1:0]  ROUTE_DECRYPT    = 2'h3;
    localparam logic [2:0]  TONE_NONE        = 3'h0;
    localparam logic [2:0]  TONE_SLOW_PIP    = 3'h1;
    localparam logic [2:0]  TONE_RAPID_PIP   = 3'h2;
    localparam logic [2:0]  TONE_TWO_TONE    = 3'h3;
    localparam logic [2:0]  TONE_CONTINUOUS  = 3'h4;
    localparam logic [2:0]  TONE_NOISE_BURST = 3'h5;
    typedef enum logic [2:0] {
        ST_RESET, ST_PRESET, ST_COPY, ST_RX_DIV, ST_STANDBY, ST_TX, ST_TIMEOUT, ST_BLOCKED
    } seq_state_t;
endpackage

// file: radio_transmit_receive_sequencer.sv
// Purpose: control sequencer of a handheld radio: start-up, standby, talk, receive routing
// Assumes: all inputs synchronous to mclk_i; one-second tick long counts are parameters
// Notes:   tone_sel_o picks a warning tone; the tone generator itself is outside
// Contract
// - talk line counts as request only after being low longer than 1 ms
// - at switch-on restart and latch range, duration and crypto-fitted presets
// - copy stored frequencies, send receive divisor, then enter standby
// - standby keeps transmit unpowered, only detection receive sections powered until a signal is detected
// - standby watches battery and warns audibly when low and no signal is detected
// - secure talk powers tx and crypto, loads tx divisor, starts timer, indicator
// - secure transmission sends sync preamble first, then encrypted voice
// - modulation buffer gain follows the transmit frequency in use
// - clear transmit bypasses encryption and adds 150 Hz squelch tone
// - clear transmit injects slow pips into local receive audio
// - wideband select with talk routes microphone straight through
// - last five seconds before time-out sound warning pips
// - on expiry stop transmitting, indicator off, two-tone warning
// - keep time-out warning until talk released, then remove it
// - keys erased: secure talk gives continuous tone, nothing transmitted
// - clear signal received is output with slow pips in any mode
// - secure signal in clear mode output still encrypted as noise
// - secure signal with other key slot selected keeps audio muted
// - secure signal with matching key slot outputs decrypted audio
// - volume 7 passes noise always; volume 6 no bursts unless battery low
// - indicator steady in transmit with good battery, flashes when low
// - preset duration picks 30, 60, 90 or 120 second limit
`timescale 1ns/1ps
module radio_transmit_receive_sequencer #(
    parameter int SEC_CYCLES   = 40_000_000,
    parameter int FLASH_CYCLES = 10_000_000
) (
    input  wire logic                      mclk_i,
    input  wire logic                      rst_i,
    input  wire logic                      talk_request_line_n_i,
    input  wire logic [1:0]                mode_i,
    input  wire logic                      wideband_select_i,
    input  wire logic [3:0]                channel_i,
    input  wire logic [3:0]                volume_i,
    input  wire logic [1:0]                preset_range_i,
    input  wire logic [1:0]                preset_duration_i,
    input  wire logic                      preset_crypto_fitted_i,
    input  wire logic                      keys_erased_i,
    input  wire logic                      battery_low_i,
    input  wire logic                      rx_detect_i,
    input  wire logic                      rx_secure_i,
    input  wire logic                      rx_key_b_i,
    input  wire logic [15:0]               store_data_i,
    input  wire logic                      crypto_sync_done_i,
    output logic [4:0]                     store_addr_o,
    output logic                           preset_latch_o,
    output logic [15:0]                    synth_divisor_o,
    output logic                           synth_load_o,
    output logic                           tx_power_o,
    output logic                           crypto_power_o,
    output logic                           rx_full_power_o,
    output logic                           crypto_tx_mode_o,
    output logic                           crypto_preamble_o,
    output logic                           crypto_bypass_o,
    output logic                           wideband_through_o,
    output logic                           squelch_tone_o,
    output logic [1:0]                     mod_gain_o,
    output logic                           tx_indicator_o,
    output logic [1:0]                     rx_route_o,
    output logic [2:0]                     tone_sel_o,
    output logic                           modulation_drive_en_o,
    output logic [radio_seq_pkg::INIT_COPY_WORDS*16-1:0] freq_mem_o
);
    import radio_seq_pkg::*;

    seq_state_t  state_reg;
    logic [15:0] talk_cnt_reg;
    logic        talk_valid_reg;
    logic [4:0]  copy_idx_reg;
    logic [15:0] freq_mem_reg [INIT_COPY_WORDS];
    logic [1:0]  range_reg;
    logic [7:0]  limit_reg;
    logic        crypto_fitted_reg;
    logic [31:0] sec_cnt_reg;
    logic [7:0]  tx_secs_reg;
    logic [31:0] pre_cnt_reg;
    logic [31:0] flash_cnt_reg;
    logic        flash_reg;
    logic [1:0]  route_next;
    logic [2:0]  tone_next;
    logic        secure_mode;

    // duration preset to limit in seconds
    function automatic logic [7:0] limit_of(input logic [1:0] sel);
        case (sel)
            2'h0:    limit_of = LIMIT_30;
            2'h1:    limit_of = LIMIT_60;
            2'h2:    limit_of = LIMIT_90;
            default: limit_of = LIMIT_120;
        endcase
    endfunction

    assign secure_mode = (mode_i == MODE_KEY_A) || (mode_i == MODE_KEY_B);

    // talk line low-time filter
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            talk_cnt_reg   <= 16'h0000;
            talk_valid_reg <= 1'b0;
        end else if (talk_request_line_n_i) begin
            talk_cnt_reg   <= 16'h0000;
            talk_valid_reg <= 1'b0;
        end else if (talk_cnt_reg >= 16'(TALK_HOLD_CYC)) begin
            talk_valid_reg <= 1'b1;
        end else begin
            talk_cnt_reg <= talk_cnt_reg + 16'h0001;
        end
    end

    // main sequence
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg    <= ST_RESET;
            copy_idx_reg <= 5'h00;
        end else begin
            case (state_reg)
                ST_RESET: begin
                    state_reg <= ST_PRESET;
                end
                ST_PRESET: begin
                    copy_idx_reg <= 5'h00;
                    state_reg    <= ST_COPY;
                end
                ST_COPY: begin
                    if (copy_idx_reg == 5'(INIT_COPY_WORDS - 1)) begin
                        state_reg <= ST_RX_DIV;
                    end else begin
                        copy_idx_reg <= copy_idx_reg + 5'h01;
                    end
                end
                ST_RX_DIV: begin
                    state_reg <= ST_STANDBY;
                end
                ST_STANDBY: begin
                    if (talk_valid_reg && secure_mode && !wideband_select_i &&
                        (keys_erased_i || !crypto_fitted_reg)) begin
                        state_reg <= ST_BLOCKED;
                    end else if (talk_valid_reg && mode_i != MODE_ZERO) begin
                        state_reg <= ST_TX;
                    end
                end
                ST_TX: begin
                    if (!talk_valid_reg) begin
                        state_reg <= ST_STANDBY;
                    end else if (tx_secs_reg >= limit_reg) begin
                        state_reg <= ST_TIMEOUT;
                    end
                end
                ST_TIMEOUT, ST_BLOCKED: begin
                    if (!talk_valid_reg) begin
                        state_reg <= ST_STANDBY;
                    end
                end
                default: state_reg <= ST_RESET;
            endcase
        end
    end

    // preset latches caught once after reset
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            range_reg         <= 2'h0;
            limit_reg         <= LIMIT_30;
            crypto_fitted_reg <= 1'b0;
        end else if (state_reg == ST_PRESET) begin
            range_reg         <= preset_range_i;
            limit_reg         <= limit_of(preset_duration_i);
            crypto_fitted_reg <= preset_crypto_fitted_i;
        end
    end

    // stored frequency copy into working memory
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < INIT_COPY_WORDS; i++) begin
                freq_mem_reg[i] <= 16'h0000;
            end
        end else if (state_reg == ST_COPY) begin
            freq_mem_reg[copy_idx_reg] <= store_data_i;
        end
    end

    // transmit timer, restarts from zero each new talk
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sec_cnt_reg <= 32'h0000_0000;
            tx_secs_reg <= 8'h00;
        end else if (state_reg != ST_TX) begin
            sec_cnt_reg <= 32'h0000_0000;
            tx_secs_reg <= 8'h00;
        end else if (sec_cnt_reg == 32'(SEC_CYCLES - 1)) begin
            sec_cnt_reg <= 32'h0000_0000;
            tx_secs_reg <= tx_secs_reg + 8'h01;
        end else begin
            sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
        end
    end

    // sync preamble window at start of secure transmission
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_cnt_reg <= 32'h0000_0000;
        end else if (state_reg != ST_TX) begin
            pre_cnt_reg <= 32'h0000_0000;
        end else if (pre_cnt_reg < 32'(SYNC_PRE_CYC) && !crypto_sync_done_i) begin
            pre_cnt_reg <= pre_cnt_reg + 32'h0000_0001;
        end else begin
            pre_cnt_reg <= 32'(SYNC_PRE_CYC);
        end
    end

    // low battery flash timebase
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            flash_cnt_reg <= 32'h0000_0000;
            flash_reg     <= 1'b0;
        end else if (flash_cnt_reg == 32'(FLASH_CYCLES - 1)) begin
            flash_cnt_reg <= 32'h0000_0000;
            flash_reg     <= ~flash_reg;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
        end
    end

    // receive route and warning tone selection
    always_comb begin
        route_next = ROUTE_MUTE;
        tone_next  = TONE_NONE;
        if (state_reg == ST_STANDBY && rx_detect_i) begin
            if (!rx_secure_i) begin
                route_next = ROUTE_CLEAR;
                tone_next  = TONE_SLOW_PIP;
            end else if (mode_i == MODE_CLEAR) begin
                route_next = ROUTE_RAW;
            end else if ((mode_i == MODE_KEY_B) == rx_key_b_i && secure_mode) begin
                route_next = ROUTE_DECRYPT;
            end else begin
                route_next = ROUTE_MUTE;
            end
        end else if (state_reg == ST_STANDBY) begin
            if (volume_i == VOL_SQ_OPEN) begin
                route_next = ROUTE_CLEAR;
            end
            if (battery_low_i) begin
                tone_next = TONE_NOISE_BURST;
            end
        end else if (state_reg == ST_TX) begin
            if (tx_secs_reg + 8'(WARN_SECONDS) >= limit_reg) begin
                tone_next = TONE_RAPID_PIP;
            end else if (mode_i == MODE_CLEAR && !wideband_select_i) begin
                tone_next = TONE_SLOW_PIP;
            end
        end else if (state_reg == ST_TIMEOUT) begin
            tone_next = TONE_TWO_TONE;
        end else if (state_reg == ST_BLOCKED) begin
            tone_next = TONE_CONTINUOUS;
        end
    end

    // registered outputs
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            store_addr_o          <= 5'h00;
            preset_latch_o        <= 1'b0;
            synth_divisor_o       <= 16'h0000;
            synth_load_o          <= 1'b0;
            tx_power_o            <= 1'b0;
            crypto_power_o        <= 1'b0;
            rx_full_power_o       <= 1'b0;
            crypto_tx_mode_o      <= 1'b0;
            crypto_preamble_o     <= 1'b0;
            crypto_bypass_o       <= 1'b0;
            wideband_through_o    <= 1'b0;
            squelch_tone_o        <= 1'b0;
            mod_gain_o            <= 2'h0;
            tx_indicator_o        <= 1'b0;
            rx_route_o            <= ROUTE_MUTE;
            tone_sel_o            <= TONE_NONE;
            modulation_drive_en_o <= 1'b0;
        end else begin
            store_addr_o    <= (state_reg == ST_COPY) ? copy_idx_reg + 5'h01 : 5'h00;
            preset_latch_o  <= (state_reg == ST_PRESET);
            synth_load_o    <= (state_reg == ST_RX_DIV) ||
                               (state_reg == ST_STANDBY && talk_valid_reg &&
                                mode_i != MODE_ZERO);
            if (state_reg == ST_STANDBY && talk_valid_reg) begin
                synth_divisor_o <= freq_mem_reg[5'(2 * channel_i + 1)];
            end else if (state_reg == ST_RX_DIV || state_reg == ST_TIMEOUT ||
                         (state_reg == ST_TX && !talk_valid_reg)) begin
                synth_divisor_o <= freq_mem_reg[5'(2 * channel_i)];
            end
            tx_power_o         <= (state_reg == ST_TX);
            crypto_power_o     <= (state_reg == ST_TX && secure_mode && !wideband_select_i) ||
                                  (state_reg == ST_STANDBY && rx_detect_i && rx_secure_i);
            rx_full_power_o    <= (state_reg == ST_STANDBY && rx_detect_i);
            crypto_tx_mode_o   <= (state_reg == ST_TX && secure_mode &&
                                   !wideband_select_i);
            crypto_preamble_o  <= (state_reg == ST_TX && secure_mode && !wideband_select_i &&
                                   pre_cnt_reg < 32'(SYNC_PRE_CYC) &&
                                   !crypto_sync_done_i);
            crypto_bypass_o    <= (state_reg == ST_TX && mode_i == MODE_CLEAR);
            wideband_through_o <= (state_reg == ST_TX && wideband_select_i);
            squelch_tone_o     <= (state_reg == ST_TX && mode_i == MODE_CLEAR &&
                                   !wideband_select_i);
            mod_gain_o         <= range_reg ^ channel_i[3:2];
            tx_indicator_o     <= (state_reg == ST_TX) &&
                                  (!battery_low_i || flash_reg);
            rx_route_o         <= route_next;
            tone_sel_o         <= tone_next;
            modulation_drive_en_o <= (state_reg == ST_TX);
        end
    end

    genvar g;
    generate
        for (g = 0; g < INIT_COPY_WORDS; g++) begin : g_mem
            assign freq_mem_o[g*16 +: 16] = freq_mem_reg[g];
        end
    endgenerate

    // checks
    a_talk_filter: assert property (@(posedge mclk_i) disable iff (rst_i)
        $rose(talk_valid_reg) |-> $past(!talk_request_line_n_i, 2))
        else $error("talk valid without sustained low");
    a_standby_tx_off: assert property (@(posedge mclk_i) disable iff (rst_i)
        $past(state_reg == ST_STANDBY) |-> !tx_power_o)
        else $error("tx powered in standby");
    a_timeout_ind_off: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_reg == ST_TIMEOUT ##1 state_reg == ST_TIMEOUT |-> !tx_indicator_o
        && tone_sel_o == TONE_TWO_TONE)
        else $error("timeout not signalled");
    a_timeout_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_reg == ST_TIMEOUT && talk_valid_reg |=> state_reg == ST_TIMEOUT)
        else $error("timeout left while talk held");
    a_blocked_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
        $past(state_reg == ST_BLOCKED) |-> !modulation_drive_en_o)
        else $error("modulation while keys erased");
    a_clear_squelch: assert property (@(posedge mclk_i) disable iff (rst_i)
        squelch_tone_o |-> $past(state_reg == ST_TX && mode_i == MODE_CLEAR))
        else $error("squelch tone outside clear tx");
    a_wrong_key_mute: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_reg == ST_STANDBY && rx_detect_i && rx_secure_i && mode_i == MODE_KEY_A
        && rx_key_b_i |=> rx_route_o == ROUTE_MUTE)
        else $error("wrong key not muted");
    a_timer_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
        $rose(state_reg == ST_TX) |-> tx_secs_reg == 8'h00)
        else $error("timer not restarted");
    a_ind_steady: assert property (@(posedge mclk_i) disable iff (rst_i)
        $past(state_reg == ST_TX && !battery_low_i) |-> tx_indicator_o)
        else $error("indicator not steady");
    c_secure_tx: cover property (@(posedge mclk_i) disable iff (rst_i)
        crypto_preamble_o ##1 !crypto_preamble_o && crypto_tx_mode_o);
    c_timeout: cover property (@(posedge mclk_i) disable iff (rst_i)
        state_reg == ST_TX ##1 state_reg == ST_TIMEOUT);
    c_blocked: cover property (@(posedge mclk_i) disable iff (rst_i)
        state_reg == ST_BLOCKED);
    c_decrypt: cover property (@(posedge mclk_i) disable iff (rst_i)
        rx_route_o == ROUTE_DECRYPT);
endmodule

// file: radio_far_side_model.sv
// Purpose: far-side model: frequency store and crypto sync answer
// Assumes: everything on mclk_i
// Notes:   sync done is low outside the preamble, never a stale level
`timescale 1ns/1ps
module radio_far_side_model #(
    parameter int SYNC_DLY = 50
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic [4:0]  store_addr_i,
    input  wire logic        preamble_i,
    output logic      [15:0] store_data_o,
    output logic             sync_done_o
);
    int cnt;
    // stored word is a known pattern of its address
    assign store_data_o = 16'h1000 + {11'h000, store_addr_i};
    // crypto reports sync some cycles into the preamble
    always_ff @(posedge mclk_i) begin
        cnt <= (rst_i || !preamble_i) ? 0 : cnt + 1;
    end
    assign sync_done_o = preamble_i && (cnt >= SYNC_DLY);
endmodule

// file: test_radio_transmit_receive_sequencer.sv
// Purpose: self-checking bench of the radio sequencer
// Assumes: one second shortened to 100 cycles
// Notes:   talk hold stays at its full 1 ms length
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module test_radio_transmit_receive_sequencer;
    import radio_seq_pkg::*;
    logic        mclk_i = 0, rst_i = 1, talk_n = 1, batt = 0;
    logic        rx_det = 0, rx_sec = 0, rx_b = 0;
    logic [1:0]  mode = MODE_KEY_A;
    logic [3:0]  chan = 4'h2, vol = 4'h3;
    logic [15:0] sdata, div;
    logic [4:0]  saddr;
    logic [1:0]  gain, route;
    logic [2:0]  tone;
    logic        latch, sdone, tx, cpw, rxf, ctx, pre, byp, sqt, ind;
    logic        wb = 0, ke = 0;
    logic        sload, wbt, mde;
    int          checked = 0, num_errors = 0, latches = 0, loads = 0;
    // clock
    initial forever #12.5 mclk_i = ~mclk_i;
    radio_transmit_receive_sequencer #(.SEC_CYCLES(100), .FLASH_CYCLES(10)) i_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .talk_request_line_n_i(talk_n), .mode_i(mode),
        .wideband_select_i(wb), .channel_i(chan), .volume_i(vol),
        .preset_range_i(2'h1), .preset_duration_i(2'h0), .preset_crypto_fitted_i(1'b1),
        .keys_erased_i(ke), .battery_low_i(batt), .rx_detect_i(rx_det),
        .rx_secure_i(rx_sec), .rx_key_b_i(rx_b), .store_data_i(sdata),
        .crypto_sync_done_i(sdone), .store_addr_o(saddr), .preset_latch_o(latch),
        .synth_divisor_o(div), .synth_load_o(sload), .tx_power_o(tx), .crypto_power_o(cpw),
        .rx_full_power_o(rxf), .crypto_tx_mode_o(ctx), .crypto_preamble_o(pre),
        .crypto_bypass_o(byp), .wideband_through_o(wbt), .squelch_tone_o(sqt),
        .mod_gain_o(gain), .tx_indicator_o(ind), .rx_route_o(route), .tone_sel_o(tone),
        .modulation_drive_en_o(mde), .freq_mem_o());
    radio_far_side_model i_far (.mclk_i(mclk_i), .rst_i(rst_i), .store_addr_i(saddr),
        .preamble_i(pre), .store_data_o(sdata), .sync_done_o(sdone));
    // count preset latch and synthesiser load pulses
    always @(posedge mclk_i) begin
        if (latch === 1'b1) latches++;
        if (sload === 1'b1) loads++;
    end
    task cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task results;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task t_start;
        cyc(40);
        `CHK("latch", 1, latches)
        `CHK("rx_div", 16'h1004, div)
        `CHK("rx_load", 1, loads)
        `CHK("tx_pwr", 1'b0, tx)
        `CHK("rx_full", 1'b0, rxf)
        $display("test start done");
    endtask
    task t_secure;
        int flips;
        logic prev;
        flips = 0;
        @(posedge mclk_i) talk_n <= 1'b0;
        cyc(39990);
        `CHK("early", 1'b0, tx)
        cyc(20);
        `CHK("tx_pwr", 1'b1, tx)
        `CHK("cr_pwr", 1'b1, cpw)
        `CHK("cr_tx", 1'b1, ctx)
        `CHK("preamble", 1'b1, pre)
        `CHK("gain", 2'h1, gain)
        `CHK("tx_div", 16'h1005, div)
        `CHK("tx_load", 2, loads)
        `CHK("mod_on", 1'b1, mde)
        cyc(80);
        `CHK("voice", 1'b0, pre)
        @(posedge mclk_i) batt <= 1'b1;
        prev = ind;
        repeat (40) begin
            @(posedge mclk_i);
            if (ind !== prev) flips++;
            prev = ind;
        end
        `CHK("flash", 1'b1, flips >= 2)
        @(posedge mclk_i) batt <= 1'b0;
        cyc(29);
        `CHK("steady", 1'b1, ind)
        cyc(2540);
        `CHK("rapid", TONE_RAPID_PIP, tone)
        `CHK("still_tx", 1'b1, tx)
        cyc(320);
        `CHK("two_tone", TONE_TWO_TONE, tone)
        `CHK("tx_off", 1'b0, tx)
        `CHK("ind_off", 1'b0, ind)
        `CHK("mod_off", 1'b0, mde)
        @(posedge mclk_i) talk_n <= 1'b1;
        cyc(5);
        `CHK("released", TONE_NONE, tone)
        $display("test secure done");
    endtask
    task t_clear;
        @(posedge mclk_i) begin
            mode <= MODE_CLEAR;
            talk_n <= 1'b0;
            ke <= 1'b1;
        end
        cyc(40010);
        `CHK("retx", 1'b1, tx)
        `CHK("bypass", 1'b1, byp)
        `CHK("sq_tone", 1'b1, sqt)
        `CHK("pips", TONE_SLOW_PIP, tone)
        `CHK("clr_keys", 1'b1, mde)
        @(posedge mclk_i) wb <= 1'b1;
        cyc(3);
        `CHK("wideband", 1'b1, wbt)
        `CHK("wb_no_sq", 1'b0, sqt)
        @(posedge mclk_i) begin
            wb <= 1'b0;
            ke <= 1'b0;
            talk_n <= 1'b1;
        end
        cyc(5);
        $display("test clear done");
    endtask
    task rx_case(input logic [1:0] m, input logic s, b, input logic [1:0] er);
        @(posedge mclk_i) begin
            mode <= m;
            rx_sec <= s;
            rx_b <= b;
            rx_det <= 1'b1;
        end
        cyc(6);
        `CHK("route", er, route)
    endtask
    task t_rx;
        rx_case(MODE_KEY_A, 1'b0, 1'b0, ROUTE_CLEAR);
        `CHK("rx_pips", TONE_SLOW_PIP, tone)
        rx_case(MODE_CLEAR, 1'b1, 1'b0, ROUTE_RAW);
        rx_case(MODE_KEY_A, 1'b1, 1'b1, ROUTE_MUTE);
        rx_case(MODE_KEY_B, 1'b1, 1'b1, ROUTE_DECRYPT);
        @(posedge mclk_i) begin
            rx_det <= 1'b0;
            vol <= VOL_SQ_OPEN;
        end
        cyc(6);
        `CHK("sq_open", ROUTE_CLEAR, route)
        @(posedge mclk_i) vol <= VOL_MAX_NORMAL;
        cyc(6);
        `CHK("no_burst", TONE_NONE, tone)
        @(posedge mclk_i) batt <= 1'b1;
        cyc(6);
        `CHK("low_batt", TONE_NOISE_BURST, tone)
        $display("test receive done");
    endtask
    // watchdog
    initial begin
        cyc(95000);
        num_errors++;
        $display("[ERR] watchdog expired");
        results();
    end
    // main sequence
    initial begin
        cyc(5);
        rst_i <= 1'b0;
        t_start();
        t_secure();
        t_clear();
        t_rx();
        results();
    end
endmodule
